// ### inc/cir_regs.svh
// Register offsets, field layout and reset values of the core interrupt routing block
`ifndef CIR_REGS_SVH
`define CIR_REGS_SVH

// Register offsets on the CSR port (byte addresses of 64-bit words)
`define CIR_OFS_STATUS 8'h00
`define CIR_OFS_MASK 8'h08
`define CIR_OFS_FORCE 8'h10
`define CIR_OFS_DLV_LO 8'h18
`define CIR_OFS_DLV_HI 8'h20

// Sources
`define CIR_NSRC 8
`define CIR_SRC_BTN 3

// Source n of status, mask and force sits at data bit (CIR_SRC0_BIT - n)
`define CIR_SRC0_BIT 31

// Delivery field of slot k sits at [CIR_FLD_TOP0 - 16k -: CIR_FLD_W]
`define CIR_FLD_TOP0 6'h39
`define CIR_FLD_W 10
`define CIR_FLD_EN0 9
`define CIR_FLD_EN1 8
`define CIR_FLD_TYP_HI 7
`define CIR_FLD_TYP_LO 6
`define CIR_FLD_NUM_HI 5

// Interrupt number in the external request word
`define CIR_EREQ_NUM_LSB 32

// Reset values
`define CIR_RST_SRC 8'h00
`define CIR_RST_WORD 64'h0000_0000_0000_0000

`endif

// ### inc/cir_pkg.sv
// Types shared by the core interrupt routing modules
package cir_pkg;

    // Exception type code held in each delivery field
    typedef enum logic [1:0] {
        CIR_EXC_INT = 2'h0,
        CIR_EXC_MCHK = 2'h1,
        CIR_EXC_XFER = 2'h2,
        CIR_EXC_PWR = 2'h3
    } cir_exc_t;

    typedef logic [9:0] cir_field_t;

endpackage

// ### inc/cir_dlv_if.sv
// Carrier between the hub logic and the delivery register store
`timescale 1ns/100ps
`default_nettype none

interface cir_dlv_if;
    logic wr_lo;
    logic wr_hi;
    logic [63:0] wdata;
    logic [63:0] rd_lo;
    logic [63:0] rd_hi;
    logic [2:0] src_sel;
    cir_pkg::cir_field_t field;

    modport hub (
        output wr_lo,
        output wr_hi,
        output wdata,
        output src_sel,
        input rd_lo,
        input rd_hi,
        input field
    );

    modport store (
        input wr_lo,
        input wr_hi,
        input wdata,
        input src_sel,
        output rd_lo,
        output rd_hi,
        output field
    );
endinterface

`default_nettype wire

// ### hw/cir_dlv_store.sv
// Processor agent delivery registers: two 64-bit words, four source fields each
`timescale 1ns/100ps
`default_nettype none
`include "cir_regs.svh"

module cir_dlv_store (
    // Clock
    input wire logic REF_CLK,
    // Hub side
    cir_dlv_if.store dlv
);

    logic [63:0] dlv_lo_r;
    logic [63:0] dlv_hi_r;
    logic [63:0] dlv_lo_nxt;
    logic [63:0] dlv_hi_nxt;
    logic [63:0] word;
    logic [5:0] top;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        dlv_lo_nxt = dlv_lo_r;
        dlv_hi_nxt = dlv_hi_r;
        if (dlv.wr_lo) begin
            dlv_lo_nxt = dlv.wdata;
        end
        if (dlv.wr_hi) begin
            dlv_hi_nxt = dlv.wdata;
        end
    end

    // No reset: contents survive a reset untouched
    always_ff @(posedge REF_CLK) begin
        dlv_lo_r <= dlv_lo_nxt;
        dlv_hi_r <= dlv_hi_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    assign dlv.rd_lo = dlv_lo_r;
    assign dlv.rd_hi = dlv_hi_r;

    // Sources 0-3 in the low word, 4-7 in the high word
    assign word = dlv.src_sel[2] ? dlv_hi_r : dlv_lo_r;
    assign top = `CIR_FLD_TOP0 - {dlv.src_sel[1:0], 4'h0};
    assign dlv.field = word[top -: `CIR_FLD_W];

endmodule

`default_nettype wire

// ### hw/cir_hub_top.sv
// Core interrupt routing: utility hub status/mask/force and processor agent delivery
`timescale 1ns/100ps
`default_nettype none
`include "cir_regs.svh"

module cir_hub_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Interrupt source pins
    input wire logic [7:0] IRQ_IN,
    // CSR access port
    input wire logic CSR_SEL,
    input wire logic CSR_WR,
    input wire logic [7:0] CSR_ADDR,
    input wire logic [63:0] CSR_WDATA,
    output logic [63:0] CSR_RDATA,
    output logic CSR_RVALID,
    // Core logic bus pending vector
    output logic [7:0] PEND_VEC,
    // Processor delivery, one bit per processor and one request word shared by both
    output logic [1:0] EXT_REQ_WR,
    output logic [63:0] EXT_REQ_DATA,
    output logic [1:0] MCHK_REQ,
    output logic [1:0] XFER_REQ
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    cir_dlv_if dlv ();

    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] sync3_r;
    logic [7:0] sync1_nxt;
    logic [7:0] sync2_nxt;
    logic [7:0] sync3_nxt;

    logic [7:0] status_r;
    logic [7:0] mask_r;
    logic [7:0] force_r;
    logic [7:0] status_nxt;
    logic [7:0] mask_nxt;
    logic [7:0] force_nxt;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] wr_bits;
    logic wr_status;
    logic wr_mask;
    logic wr_force;
    logic rd_req;

    logic [63:0] rdata_r;
    logic [63:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    logic [7:0] pend_r;
    logic [7:0] pend_nxt;
    logic [7:0] prev_r;
    logic [7:0] prev_nxt;
    logic [7:0] todo_r;
    logic [7:0] todo_nxt;
    logic [7:0] served;
    logic [2:0] pick;
    logic have;

    cir_pkg::cir_exc_t exc;
    logic [1:0] en;
    logic [5:0] num;
    logic [1:0] ereq_r;
    logic [1:0] ereq_nxt;
    logic [63:0] edata_r;
    logic [63:0] edata_nxt;
    logic [1:0] mchk_r;
    logic [1:0] mchk_nxt;
    logic [1:0] xfer_r;
    logic [1:0] xfer_nxt;

    // Source n lives at data bit (31 - n), the msb-first bit order of the map
    function automatic logic [7:0] word_to_src(input logic [63:0] w);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < `CIR_NSRC; i++) begin
            r[i] = w[`CIR_SRC0_BIT - i];
        end
        return r;
    endfunction

    function automatic logic [63:0] src_to_word(input logic [7:0] s);
        logic [63:0] r;
        r = `CIR_RST_WORD;
        for (int i = 0; i < `CIR_NSRC; i++) begin
            r[`CIR_SRC0_BIT - i] = s[i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; third stage only feeds the button edge detector

    always_comb begin
        sync1_nxt = IRQ_IN;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync1_r <= `CIR_RST_SRC;
            sync2_r <= `CIR_RST_SRC;
            sync3_r <= `CIR_RST_SRC;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CSR decode

    always_comb begin
        rd_req = CSR_SEL && !CSR_WR;
        wr_status = CSR_SEL && CSR_WR && (CSR_ADDR == `CIR_OFS_STATUS);
        wr_mask = CSR_SEL && CSR_WR && (CSR_ADDR == `CIR_OFS_MASK);
        wr_force = CSR_SEL && CSR_WR && (CSR_ADDR == `CIR_OFS_FORCE);
        wr_bits = word_to_src(CSR_WDATA);
    end

    assign dlv.wr_lo = CSR_SEL && CSR_WR && (CSR_ADDR == `CIR_OFS_DLV_LO);
    assign dlv.wr_hi = CSR_SEL && CSR_WR && (CSR_ADDR == `CIR_OFS_DLV_HI);
    assign dlv.wdata = CSR_WDATA;

    ////////////////////////////////////////////////////////////////////////
    // Status, mask and force

    always_comb begin
        set_vec = sync2_r;
        // Button counts once per press, however long it is held
        set_vec[`CIR_SRC_BTN] = sync2_r[`CIR_SRC_BTN] && !sync3_r[`CIR_SRC_BTN];
        clr_vec = wr_status ? wr_bits : 8'h00;
        for (int i = 0; i < `CIR_NSRC; i++) begin
            if (i == `CIR_SRC_BTN) begin
                // An edge would never come back, so it must not be lost
                status_nxt[i] = (status_r[i] && !clr_vec[i]) || set_vec[i];
            end else begin
                // A still-active level sets the bit again next cycle
                status_nxt[i] = (status_r[i] || set_vec[i]) && !clr_vec[i];
            end
        end
        mask_nxt = wr_mask ? wr_bits : mask_r;
        force_nxt = wr_force ? wr_bits : force_r;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            status_r <= `CIR_RST_SRC;
            mask_r <= `CIR_RST_SRC;
            force_r <= `CIR_RST_SRC;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            force_r <= force_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CSR read answer, one cycle after the request

    always_comb begin
        rvalid_nxt = rd_req;
        rdata_nxt = rdata_r;
        if (rd_req) begin
            unique case (CSR_ADDR)
                `CIR_OFS_STATUS: rdata_nxt = src_to_word(status_r);
                `CIR_OFS_MASK: rdata_nxt = src_to_word(mask_r);
                `CIR_OFS_FORCE: rdata_nxt = src_to_word(force_r);
                `CIR_OFS_DLV_LO: rdata_nxt = dlv.rd_lo;
                `CIR_OFS_DLV_HI: rdata_nxt = dlv.rd_hi;
                default: rdata_nxt = `CIR_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= `CIR_RST_WORD;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign CSR_RDATA = rdata_r;
    assign CSR_RVALID = rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // Pending vector broadcast on the core logic bus

    always_comb begin
        pend_nxt = (status_r & ~mask_r) | force_r;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pend_r <= `CIR_RST_SRC;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // Same vector for every agent; each one applies its own enables
    assign PEND_VEC = pend_r;

    ////////////////////////////////////////////////////////////////////////
    // Agent: new pending sources queue up, lowest number served first

    always_comb begin
        have = 1'b0;
        pick = 3'h0;
        for (int i = `CIR_NSRC - 1; i >= 0; i--) begin
            if (todo_r[i]) begin
                have = 1'b1;
                pick = 3'(i);
            end
        end
        served = have ? (8'h01 << pick) : 8'h00;
        prev_nxt = pend_r;
        // A fresh rising bit wins over serving it in the same cycle
        todo_nxt = (todo_r & ~served) | (pend_r & ~prev_r);
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            prev_r <= `CIR_RST_SRC;
            todo_r <= `CIR_RST_SRC;
        end else begin
            prev_r <= prev_nxt;
            todo_r <= todo_nxt;
        end
    end

    assign dlv.src_sel = pick;

    cir_dlv_store cir_dlv_store_inst (
        .REF_CLK(REF_CLK),
        .dlv(dlv)
    );

    ////////////////////////////////////////////////////////////////////////
    // Delivery to the two processors

    always_comb begin
        en[0] = dlv.field[`CIR_FLD_EN0];
        en[1] = dlv.field[`CIR_FLD_EN1];
        exc = cir_pkg::cir_exc_t'(dlv.field[`CIR_FLD_TYP_HI:`CIR_FLD_TYP_LO]);
        num = dlv.field[`CIR_FLD_NUM_HI:0];
        ereq_nxt = 2'h0;
        mchk_nxt = 2'h0;
        xfer_nxt = 2'h0;
        edata_nxt = edata_r;
        for (int p = 0; p < 2; p++) begin
            if (have && en[p]) begin
                unique case (exc)
                    cir_pkg::CIR_EXC_INT,
                    cir_pkg::CIR_EXC_PWR: ereq_nxt[p] = 1'b1;
                    cir_pkg::CIR_EXC_MCHK: mchk_nxt[p] = 1'b1;
                    cir_pkg::CIR_EXC_XFER: xfer_nxt[p] = 1'b1;
                endcase
            end
        end
        if (ereq_nxt != 2'h0) begin
            // Whole double word always written; no read-back path exists
            edata_nxt = `CIR_RST_WORD;
            edata_nxt[`CIR_EREQ_NUM_LSB +: 6] = num;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ereq_r <= 2'h0;
            edata_r <= `CIR_RST_WORD;
            mchk_r <= 2'h0;
            xfer_r <= 2'h0;
        end else begin
            ereq_r <= ereq_nxt;
            edata_r <= edata_nxt;
            mchk_r <= mchk_nxt;
            xfer_r <= xfer_nxt;
        end
    end

    assign EXT_REQ_WR = ereq_r;
    assign EXT_REQ_DATA = edata_r;
    assign MCHK_REQ = mchk_r;
    assign XFER_REQ = xfer_r;

endmodule

`default_nettype wire

// ### verif/cir_hub_top_props.sv
// Port-level checks on the core interrupt routing top
`timescale 1ns/100ps
`default_nettype none
module cir_hub_props (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // CSR port
    input wire logic CSR_SEL,
    input wire logic CSR_WR,
    input wire logic [7:0] CSR_ADDR,
    input wire logic [63:0] CSR_WDATA,
    input wire logic [63:0] CSR_RDATA,
    input wire logic CSR_RVALID,
    // Delivery side
    input wire logic [7:0] PEND_VEC,
    input wire logic [1:0] EXT_REQ_WR,
    input wire logic [63:0] EXT_REQ_DATA,
    input wire logic [1:0] MCHK_REQ,
    input wire logic [1:0] XFER_REQ
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    logic [7:0] wbits;
    // Source n travels on data bit 31-n
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            wbits[n] = CSR_WDATA[31 - n];
        end
    end
    sequence s_rd;
        CSR_SEL && !CSR_WR;
    endsequence
    sequence s_force_wr;
        CSR_SEL && CSR_WR && CSR_ADDR == 8'h10 ##1 !CSR_SEL;
    endsequence
    property p_rd_answer;
        s_rd |=> CSR_RVALID;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_wr_silent;
        CSR_SEL && CSR_WR |=> !CSR_RVALID;
    endproperty
    a_wr_silent: assert property (p_wr_silent) else $error("write answered");
    property p_stat_rsv;
        s_rd ##0 CSR_ADDR == 8'h00 |=> CSR_RDATA[63:32] == 32'h0 && CSR_RDATA[23:0] == 24'h0;
    endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status spare bits set");
    property p_ctl_rsv;
        s_rd ##0 (CSR_ADDR == 8'h08 || CSR_ADDR == 8'h10) |=> CSR_RDATA[23:0] == 24'h0;
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("mask or force spare bits");
    property p_force_pend;
        s_force_wr |=> (PEND_VEC & $past(wbits, 2)) == $past(wbits, 2);
    endproperty
    a_force_pend: assert property (p_force_pend) else $error("forced source not pending");
    property p_req_fmt;
        |EXT_REQ_WR |-> EXT_REQ_DATA[63:38] == 26'h0 && EXT_REQ_DATA[31:0] == 32'h0;
    endproperty
    a_req_fmt: assert property (p_req_fmt) else $error("request word malformed");
    property p_one_kind;
        $onehot0({|EXT_REQ_WR, |MCHK_REQ, |XFER_REQ});
    endproperty
    a_one_kind: assert property (p_one_kind) else $error("two delivery kinds at once");
    property p_rst_quiet;
        $fell(RST) |-> PEND_VEC == 8'h00 && EXT_REQ_WR == 2'h0 && !CSR_RVALID;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
endmodule
bind cir_hub_top cir_hub_props cir_hub_props_inst (.REF_CLK(REF_CLK), .RST(RST),
    .CSR_SEL(CSR_SEL), .CSR_WR(CSR_WR), .CSR_ADDR(CSR_ADDR), .CSR_WDATA(CSR_WDATA),
    .CSR_RDATA(CSR_RDATA), .CSR_RVALID(CSR_RVALID), .PEND_VEC(PEND_VEC),
    .EXT_REQ_WR(EXT_REQ_WR), .EXT_REQ_DATA(EXT_REQ_DATA), .MCHK_REQ(MCHK_REQ),
    .XFER_REQ(XFER_REQ));
`default_nettype wire

// ### verif/cir_proc_model.sv
// Two-processor model that logs what the agent delivers
`timescale 1ns/100ps
`default_nettype none
module cir_proc_model (
    // Clock
    input wire logic ref_clk,
    // Agent requests
    input wire logic [1:0] ext_req_wr,
    input wire logic [63:0] ext_req_data,
    input wire logic [1:0] mchk_req,
    input wire logic [1:0] xfer_req,
    // Bytes: ext1 ext0 mchk1 mchk0 xfer1 xfer0
    output var logic [47:0] cnt,
    output var logic [5:0] last_num
);
    initial cnt = 48'h0;
    initial last_num = 6'h00;
    always @(posedge ref_clk) begin
        for (int p = 0; p < 2; p++) begin
            // Only the number in bits 37:32 is kept, never read back
            if (ext_req_wr[p] === 1'b1) begin
                cnt[32 + 8 * p +: 8] <= cnt[32 + 8 * p +: 8] + 8'h01;
                last_num <= ext_req_data[37:32];
            end
            if (mchk_req[p] === 1'b1) begin
                cnt[16 + 8 * p +: 8] <= cnt[16 + 8 * p +: 8] + 8'h01;
            end
            if (xfer_req[p] === 1'b1) begin
                cnt[8 * p +: 8] <= cnt[8 * p +: 8] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/cir_hub_top_bench.sv
// Self-checking bench for the core interrupt routing top
`timescale 1ns/100ps
`default_nettype none
`include "cir_regs.svh"
module cir_hub_top_bench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] irq_in = 8'h00;
    logic csr_sel = 1'b0;
    logic csr_wr = 1'b0;
    logic [7:0] csr_addr = 8'h00;
    logic [63:0] csr_wdata = 64'h0;
    logic [63:0] csr_rdata;
    logic csr_rvalid;
    logic [7:0] pend_vec;
    logic [1:0] ext_req_wr;
    logic [63:0] ext_req_data;
    logic [1:0] mchk_req;
    logic [1:0] xfer_req;
    logic [47:0] cnt;
    logic [47:0] base;
    logic [5:0] last_num;
    logic [63:0] rd;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // src0 p0 int 05, src1 both int 21, src3 p0 transfer
    localparam logic [63:0] DLO = 64'h0205_0321_0000_0280;
    // src5 p1 check, src7 p1 power 3F; src2/4/6 unrouted
    localparam logic [63:0] DHI = 64'h0000_0140_0000_01FF;
    always #25 ref_clk = ~ref_clk;
    cir_hub_top cir_hub_top_inst (.REF_CLK(ref_clk), .RST(rst), .IRQ_IN(irq_in),
        .CSR_SEL(csr_sel), .CSR_WR(csr_wr), .CSR_ADDR(csr_addr), .CSR_WDATA(csr_wdata),
        .CSR_RDATA(csr_rdata), .CSR_RVALID(csr_rvalid), .PEND_VEC(pend_vec),
        .EXT_REQ_WR(ext_req_wr), .EXT_REQ_DATA(ext_req_data), .MCHK_REQ(mchk_req),
        .XFER_REQ(xfer_req));
    cir_proc_model cir_proc_model_inst (.ref_clk(ref_clk), .ext_req_wr(ext_req_wr),
        .ext_req_data(ext_req_data), .mchk_req(mchk_req), .xfer_req(xfer_req), .cnt(cnt),
        .last_num(last_num));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic csr(input logic wr, input logic [7:0] a, input logic [63:0] d);
        @(posedge ref_clk);
        #5;
        csr_sel = 1'b1;
        csr_wr = wr;
        csr_addr = a;
        csr_wdata = d;
        @(posedge ref_clk);
        #5;
        csr_sel = 1'b0;
        // Strobe and data both stand from the taking edge to the next one
        rd = csr_rdata;
        check("read strobe", {63'h0, csr_rvalid}, {63'h0, !wr});
    endtask
    task automatic rdx(input string w, input logic [7:0] a, input logic [63:0] e);
        csr(1'b0, a, 64'h0);
        check(w, rd, e);
    endtask
    // Sync, pending and queue take about six edges; twelve leaves margin
    task automatic dl(input logic [47:0] d);
        repeat (12) @(posedge ref_clk);
        #5;
        check("deliveries", {16'h0, cnt}, {16'h0, base + d});
        base = cnt;
    endtask
    task automatic drop(input logic [7:0] clr);
        irq_in = 8'h00;
        repeat (4) @(posedge ref_clk);
        csr(1'b1, `CIR_OFS_STATUS, {32'h0, clr, 24'h0});
    endtask
    task automatic t_reset;
        rdx("status", `CIR_OFS_STATUS, 64'h0);
        rdx("mask", `CIR_OFS_MASK, 64'h0);
        rdx("force", `CIR_OFS_FORCE, 64'h0);
        csr(1'b1, `CIR_OFS_STATUS, 64'hFFFF_FFFF_00FF_FFFF);
        rdx("status", `CIR_OFS_STATUS, 64'h0);
        rdx("unmapped", 8'h28, 64'h0);
        $display("done reset");
    endtask
    task automatic t_dlv;
        csr(1'b1, `CIR_OFS_DLV_LO, DLO);
        csr(1'b1, `CIR_OFS_DLV_HI, DHI);
        rdx("dlv low", `CIR_OFS_DLV_LO, DLO);
        rdx("dlv high", `CIR_OFS_DLV_HI, DHI);
        @(posedge ref_clk);
        #5;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #5;
        rst = 1'b0;
        rdx("dlv low", `CIR_OFS_DLV_LO, DLO);
        rdx("dlv high", `CIR_OFS_DLV_HI, DHI);
        $display("done delivery regs");
    endtask
    task automatic t_level;
        base = cnt;
        irq_in[1:0] = 2'b11;
        dl(48'h01_02_00_00_00_00);
        check("number", {58'h0, last_num}, 64'h21);
        rdx("status", `CIR_OFS_STATUS, 64'hC000_0000);
        csr(1'b1, `CIR_OFS_STATUS, 64'hC000_0000);
        dl(48'h01_02_00_00_00_00);
        drop(8'hC0);
        rdx("status", `CIR_OFS_STATUS, 64'h0);
        $display("done level");
    endtask
    task automatic t_mask;
        base = cnt;
        csr(1'b1, `CIR_OFS_MASK, 64'hFFFF_FFFF_0400_0000);
        rdx("mask", `CIR_OFS_MASK, 64'h0400_0000);
        irq_in[5] = 1'b1;
        dl(48'h0);
        check("pending", {56'h0, pend_vec}, 64'h0);
        rdx("status", `CIR_OFS_STATUS, 64'h0400_0000);
        csr(1'b1, `CIR_OFS_FORCE, 64'h0400_0000);
        dl(48'h00_00_01_00_00_00);
        rdx("force", `CIR_OFS_FORCE, 64'h0400_0000);
        drop(8'h04);
        csr(1'b1, `CIR_OFS_FORCE, 64'h0);
        csr(1'b1, `CIR_OFS_MASK, 64'h0);
        $display("done mask");
    endtask
    task automatic t_button;
        base = cnt;
        irq_in[3] = 1'b1;
        dl(48'h00_00_00_00_00_01);
        csr(1'b1, `CIR_OFS_STATUS, 64'h1000_0000);
        dl(48'h0);
        rdx("status", `CIR_OFS_STATUS, 64'h0);
        drop(8'h00);
        $display("done button");
    endtask
    task automatic t_power;
        base = cnt;
        irq_in[7] = 1'b1;
        dl(48'h01_00_00_00_00_00);
        check("number", {58'h0, last_num}, 64'h3F);
        drop(8'h01);
        $display("done power");
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        #5;
        rst = 1'b0;
        t_reset;
        t_dlv;
        t_level;
        t_mask;
        t_button;
        t_power;
        close_out;
    end
endmodule
`default_nettype wire
